// >>> rtl/dpcs_top.sv
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
// Summary of operation
// - only the controlling port's clear erases unit fault status
// - controller's clear leaves the other port's nibble and attention alone
// - unit alarms never touch the ownership status byte
// - command from non-owner is rejected, attention raised, rejected bits set
// - port one command while port zero owns gives byte 0xc1
// - takeover with fault pending raises both attentions, byte 0x74
// - attention holds while the port's own status bits are set
// - non-owner clear drops its own bits, 0x1c to 0x10, releases attention
// - owner bad command: attention, error byte 0x80, read word 0x0002
// - temperature warning low within five degrees of shutdown
// - output-loss warning low when output loss is imminent
// - during overload the output-loss warning pulses at 1 ms period
// - non-shutdown faults reported as non-catastrophic internal failure
// - main output on only while enable strap held at ground
// - address bits three to zero from first and second level inputs
// - input lamp off in RS-485 mode, otherwise steady when input ok, blinking when out of limits
module dpcs_top
  import dpcs_pkg::*;
#(
  parameter int PG_HALF    = PG_HALF_CYC,
  parameter int BLINK_HALF = BLINK_HALF_CYC,
  parameter int TEMP_SHDN  = TEMP_SHDN_C
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  output logic              irq,
  input  wire dpcs_port_s   port [NPORT],
  input  wire logic         unit_fault,
  input  wire logic         noncat_fail,
  input  wire logic [7:0]   temp_c,
  input  wire logic         loss_imminent,
  input  wire logic         overload,
  input  wire logic         input_present,
  input  wire logic         input_ok,
  input  wire logic         output_ok,
  input  wire logic         enable_strap_n,
  input  wire logic         rs485_mode,
  input  wire logic [1:0]   addr_level_first,
  input  wire logic [1:0]   addr_level_second,
  output dpcs_od_s          od_oe,
  output dpcs_od_s          od_o,
  output logic              main_out_on,
  output logic [3:0]        bus_addr_low,
  output logic              input_lamp,
  output logic              output_lamp,
  output logic              module_present_out
);

  initial begin
    if (PG_HALF < 1 || BLINK_HALF < 1 || TEMP_SHDN < OTW_MARGIN_C)
      $error("dpcs_top: parameter out of range");
  end

  // synchronised pins
  localparam int PW = 4;
  localparam int MW = 9 + 8;
  logic [PW-1:0] port_q [NPORT];
  logic [MW-1:0] misc_q;
  logic [NPORT-1:0] lclk_d;
  logic unit_fault_q, noncat_q, loss_q, ovl_q, inp_pres_q, inp_ok_q;
  logic out_ok_q, strap_n_q, rs485_q;
  logic [7:0] temp_q;

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port_sync
      dpcs_sync #(.W(PW)) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({port[gp].link_clk, port[gp].evt}),
        .q     (port_q[gp])
      );
    end
  endgenerate

  dpcs_sync #(.W(MW)) u_misc_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({unit_fault, noncat_fail, loss_imminent, overload,
             input_present, input_ok, output_ok, enable_strap_n,
             rs485_mode, temp_c}),
    .q     (misc_q)
  );
  assign {unit_fault_q, noncat_q, loss_q, ovl_q, inp_pres_q, inp_ok_q,
          out_ok_q, strap_n_q, rs485_q, temp_q} = misc_q;

  // link clock edge detect on the synchronised copy
  logic [2:0] evt_take [NPORT];
  always_ff @(posedge clk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (reset) begin
        lclk_d[p]   <= 1'b0;
        evt_take[p] <= 3'h0;
      end else begin
        lclk_d[p]   <= port_q[p][3];
        evt_take[p] <= (port_q[p][3] && !lclk_d[p]) ? port_q[p][2:0] : 3'h0;
      end
    end
  end

  // ownership and unit status
  logic [7:0]  bus_st;
  logic [7:0]  cml;
  logic [15:0] rd_word;
  logic        fault_lat, noncat_lat;
  logic        owner;
  logic [7:0]  next_bus;
  logic [7:0]  next_cml;
  logic [15:0] next_rd;
  logic        next_owner, unit_clr;
  logic [IRQ_W-1:0] ev;

  function automatic logic is_evt(input logic [2:0] c, input dpcs_evt_e e);
    return c == 3'(e);
  endfunction

  // event decode, port zero first then port one
  always_comb begin
    next_bus   = bus_st;
    next_cml   = cml;
    next_rd    = rd_word;
    next_owner = owner;
    unit_clr   = 1'b0;
    ev         = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (is_evt(evt_take[p], EV_CMD) && next_owner != 1'(p)) begin
        next_bus[p*NIB_W + NIB_REJ]   = 1'b1;
        next_bus[p*NIB_W + NIB_OTHER] = 1'b1;
        ev[IRQ_REJECT] = 1'b1;
      end
      if (is_evt(evt_take[p], EV_BAD_CMD)) begin
        if (next_owner == 1'(p)) begin
          next_cml = CML_BAD;
          next_rd  = RD_BAD;
          ev[IRQ_BADCMD] = 1'b1;
        end else begin
          next_bus[p*NIB_W + NIB_REJ]   = 1'b1;
          next_bus[p*NIB_W + NIB_OTHER] = 1'b1;
          ev[IRQ_REJECT] = 1'b1;
        end
      end
      if (is_evt(evt_take[p], EV_TAKEOVER) && next_owner != 1'(p)) begin
        next_bus[(1-p)*NIB_W +: NIB_W] = 4'h0;
        next_bus[(1-p)*NIB_W + NIB_OTHER] = 1'b1;
        next_bus[p*NIB_W + NIB_CTL]   = 1'b1;
        next_bus[p*NIB_W + NIB_TAKE]  = 1'b1;
        next_bus[p*NIB_W + NIB_OTHER] = 1'b1;
        next_owner = 1'(p);
        ev[IRQ_TAKE] = 1'b1;
      end
      if (is_evt(evt_take[p], EV_CLEAR)) begin
        next_bus[p*NIB_W + 1 +: NIB_W-1] = 3'h0;
        ev[IRQ_CLEAR] = 1'b1;
        if (next_owner == 1'(p)) begin
          unit_clr = 1'b1;
          next_cml = 8'h00;
          next_rd  = 16'h0000;
        end
      end
    end
  end

  // byte fed only by port events
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_st  <= BUS_RESET;
      owner   <= 1'b0;
      cml     <= 8'h00;
      rd_word <= 16'h0000;
    end else begin
      bus_st  <= next_bus;
      owner   <= next_owner;
      cml     <= next_cml;
      rd_word <= next_rd;
    end
  end

  // latched faults, a persisting fault sets again
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_lat  <= 1'b0;
      noncat_lat <= 1'b0;
    end else begin
      fault_lat  <= unit_fault_q || (fault_lat && !unit_clr);
      noncat_lat <= noncat_q || (noncat_lat && !unit_clr);
    end
  end

  logic [NPORT-1:0] attn;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      attn[p] = |bus_st[p*NIB_W + 1 +: NIB_W-1] ||
                (owner == 1'(p) &&
                 (fault_lat || noncat_lat || cml != 8'h00));
    end
  end

  // pulse and blink generators
  logic pg_phase, blink_phase;
  dpcs_blink #(.HALF(PG_HALF)) u_pg_pulse (
    .clk   (clk),
    .reset (reset),
    .run   (ovl_q),
    .phase (pg_phase)
  );
  dpcs_blink #(.HALF(BLINK_HALF)) u_lamp_blink (
    .clk   (clk),
    .reset (reset),
    .run   (1'b1),
    .phase (blink_phase)
  );

  // register bus state
  logic             ctrl_out_en;
  logic [IRQ_W-1:0] istat, imask;
  logic             rd_done, wr_done;
  logic             istat_rd;
  assign rd_done  = avs_read && !avs_waitrequest;
  assign wr_done  = avs_write && !avs_waitrequest;
  assign istat_rd = rd_done && avs_address == OFS_ISTAT;

  // one wait cycle, then completion edge
  always_ff @(posedge clk) begin
    if (reset)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // read mux, sampled during the wait cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        OFS_CTRL:  avs_readdata <= {31'h0, ctrl_out_en};
        OFS_BUS:   avs_readdata <= {23'h0, owner, bus_st};
        OFS_UNIT:  avs_readdata <= {rd_word, cml, 6'h0, noncat_lat,
                                    fault_lat};
        OFS_ISTAT: avs_readdata <= {27'h0, istat};
        OFS_IMASK: avs_readdata <= {27'h0, imask};
        OFS_ADDR:  avs_readdata <= {28'h0, bus_addr_low};
        default:   avs_readdata <= UNMAPPED;
      endcase
    end
  end

  // writable control and mask
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_out_en <= 1'b1;
      imask       <= '0;
    end else if (wr_done && avs_byteenable[0]) begin
      if (avs_address == OFS_CTRL)
        ctrl_out_en <= avs_writedata[0];
      if (avs_address == OFS_IMASK)
        imask <= avs_writedata[IRQ_W-1:0];
    end
  end

  // sticky status, set wins over read-clear
  logic fault_d;
  always_ff @(posedge clk) begin
    if (reset) begin
      istat   <= '0;
      fault_d <= 1'b0;
    end else begin
      fault_d <= fault_lat;
      istat   <= (istat & {IRQ_W{!istat_rd}}) | ev |
                 (IRQ_W'(fault_lat && !fault_d) << IRQ_FAULT);
    end
  end

  // level interrupt
  always_ff @(posedge clk) begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(istat & imask);
  end

  // address levels synchronised, captured once settled
  logic [3:0] next_addr;
  logic [1:0] addr_wait;
  logic       addr_cap;
  dpcs_sync #(.W(4)) u_addr_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({addr_level_first, addr_level_second}),
    .q     (next_addr)
  );

  // wait for the synchroniser to fill before the one capture
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_wait    <= 2'h0;
      addr_cap     <= 1'b0;
      bus_addr_low <= 4'h0;
    end else if (!addr_cap) begin
      if (addr_wait == 2'h2) begin
        addr_cap     <= 1'b1;
        bus_addr_low <= next_addr;
      end else begin
        addr_wait <= addr_wait + 2'h1;
      end
    end
  end

  // open-drain pins and lamps
  always_ff @(posedge clk) begin
    if (reset) begin
      od_oe              <= '0;
      od_o               <= '0;
      main_out_on        <= 1'b0;
      input_lamp         <= 1'b0;
      output_lamp        <= 1'b0;
      module_present_out <= 1'b0;
    end else begin
      od_o               <= '0;
      od_oe.attention    <= attn;
      od_oe.fault        <= fault_lat || noncat_lat;
      od_oe.overtemp_warn <=
        temp_q >= 8'(TEMP_SHDN - OTW_MARGIN_C);
      od_oe.output_loss_warn <= ovl_q ? pg_phase : (loss_q || !out_ok_q);
      main_out_on <= !strap_n_q && !rs485_q && ctrl_out_en;
      input_lamp  <= !rs485_q &&
                     (inp_ok_q || (inp_pres_q && blink_phase));
      output_lamp <= out_ok_q && (!ovl_q || blink_phase);
      module_present_out <= 1'b0;
    end
  end

  // port one rejected while port zero owns
  chk_reject_code: assert property (@(posedge clk) disable iff (reset)
    is_evt(evt_take[1], EV_CMD) && owner == 1'b0 && bus_st == BUS_RESET
    && evt_take[0] == 3'h0 |=> bus_st == 8'hc1 ##2 od_oe.attention[1])
    else $error("rejected command did not give 0xc1");
  chk_reject_bits: assert property (@(posedge clk) disable iff (reset)
    is_evt(evt_take[0], EV_CMD) && owner == 1'b1 |=>
    bus_st[NIB_REJ] && bus_st[NIB_OTHER])
    else $error("rejected command bits missing");
  chk_takeover_code: assert property (@(posedge clk) disable iff (reset)
    is_evt(evt_take[1], EV_TAKEOVER) && owner == 1'b0 &&
    bus_st == BUS_RESET && evt_take[0] == 3'h0 |=>
    bus_st == 8'h74 ##2 (&od_oe.attention || !fault_lat))
    else $error("takeover did not give 0x74");
  chk_clear_other: assert property (@(posedge clk) disable iff (reset)
    is_evt(evt_take[1], EV_CLEAR) && owner == 1'b0 && evt_take[0] == 3'h0
    && !unit_fault_q && fault_lat |=> fault_lat)
    else $error("non-owner clear erased fault");
  chk_clear_keeps: assert property (@(posedge clk) disable iff (reset)
    is_evt(evt_take[0], EV_CLEAR) && owner == 1'b0 && evt_take[1] == 3'h0
    |=> bus_st[7:4] == $past(bus_st[7:4]))
    else $error("owner clear touched other nibble");
  chk_clear_own: assert property (@(posedge clk) disable iff (reset)
    bus_st == 8'h1c && is_evt(evt_take[0], EV_CLEAR) && evt_take[1] == 3'h0
    |=> bus_st == 8'h10 ##2 !od_oe.attention[0])
    else $error("own clear did not give 0x10");
  chk_attn_hold: assert property (@(posedge clk) disable iff (reset)
    |bus_st[3:1] ##1 |bus_st[3:1] |=> od_oe.attention[0])
    else $error("attention dropped with status bits set");
  chk_bad_cmd: assert property (@(posedge clk) disable iff (reset)
    is_evt(evt_take[owner], EV_BAD_CMD) && evt_take[!owner] == 3'h0
    |=> cml == CML_BAD && rd_word == RD_BAD)
    else $error("bad command not reported");
  chk_alarm_bus: assert property (@(posedge clk) disable iff (reset)
    evt_take[0] == 3'h0 && evt_take[1] == 3'h0 |=> $stable(bus_st))
    else $error("status byte changed without port event");
  chk_strap_out: assert property (@(posedge clk) disable iff (reset)
    strap_n_q |=> !main_out_on)
    else $error("output on with strap released");
  chk_pg_pulse: assert property (@(posedge clk) disable iff (reset)
    ovl_q && $past(ovl_q) && $rose(pg_phase) |=>
    od_oe.output_loss_warn)
    else $error("loss warning not pulsing");
  cov_takeover: cover property (@(posedge clk) disable iff (reset)
    bus_st == 8'h74);
  cov_reject: cover property (@(posedge clk) disable iff (reset)
    bus_st == 8'h1c ##[1:200] bus_st == 8'h10);
  cov_irq: cover property (@(posedge clk) disable iff (reset) $rose(irq));

endmodule

// >>> rtl/dpcs_pkg.sv
package dpcs_pkg;

  // port count and link event codes
  localparam int NPORT = 2;
  typedef enum logic [2:0] {
    EV_NONE,
    EV_CMD,
    EV_BAD_CMD,
    EV_CLEAR,
    EV_TAKEOVER
  } dpcs_evt_e;

  // one management port as seen at the pins
  typedef struct packed {
    logic       link_clk;
    logic [2:0] evt;
  } dpcs_port_s;

  // open-drain enables, high while the pin is pulled low
  typedef struct packed {
    logic       fault;
    logic       overtemp_warn;
    logic       output_loss_warn;
    logic [1:0] attention;
  } dpcs_od_s;

  // ownership nibble layout, one nibble per port
  localparam int NIB_W     = 4;
  localparam int NIB_CTL   = 0;
  localparam int NIB_TAKE  = 1;
  localparam int NIB_OTHER = 2;
  localparam int NIB_REJ   = 3;
  localparam logic [7:0]  BUS_RESET = 8'h01;
  localparam logic [7:0]  CML_BAD   = 8'h80;
  localparam logic [15:0] RD_BAD    = 16'h0002;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BUS    = 8'h04;
  localparam logic [7:0] OFS_UNIT   = 8'h08;
  localparam logic [7:0] OFS_ISTAT  = 8'h0c;
  localparam logic [7:0] OFS_IMASK  = 8'h10;
  localparam logic [7:0] OFS_ADDR   = 8'h14;
  localparam logic [31:0] UNMAPPED  = 32'hdeadbeef;

  // interrupt event bits
  localparam int IRQ_W       = 5;
  localparam int IRQ_REJECT  = 0;
  localparam int IRQ_TAKE    = 1;
  localparam int IRQ_BADCMD  = 2;
  localparam int IRQ_FAULT   = 3;
  localparam int IRQ_CLEAR   = 4;

  // unit status field positions
  localparam int UNIT_FAULT  = 0;
  localparam int UNIT_NONCAT = 1;
  localparam int UNIT_CML    = 8;
  localparam int UNIT_RD     = 16;

  // timing
  localparam int CLK_MHZ        = 200;
  localparam int OTW_MARGIN_C   = 5;
  localparam int TEMP_SHDN_C    = 100;
  localparam int PG_PERIOD_US   = 1000;
  localparam int PG_HALF_CYC    = PG_PERIOD_US * CLK_MHZ / 2;
  localparam int BLINK_PERIOD_US = 500000;
  localparam int BLINK_HALF_CYC = BLINK_PERIOD_US / 2 * CLK_MHZ;

endpackage

// >>> rtl/dpcs_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for pin levels
module dpcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// >>> rtl/dpcs_blink.sv
`timescale 1ns/100ps
// square wave while run is high, low when idle
module dpcs_blink #(
  parameter int HALF = 100000
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic run,
  output logic      phase
);
  logic [31:0] cnt;

  initial begin
    if (HALF < 1) $error("dpcs_blink: HALF must be at least one");
  end

  // half-period counter, restarts when stopped
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt   <= '0;
      phase <= 1'b0;
    end else if (cnt == 32'(HALF - 1)) begin
      cnt   <= '0;
      phase <= !phase;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
endmodule

// >>> sim/dpcs_host.sv
`timescale 1ns/100ps
// host on one management port, one event per link clock pulse
module dpcs_host
  import dpcs_pkg::*;
(
  output dpcs_port_s port_o
);
  // link clock stands low between frames
  initial port_o = '0;

  // one frame, prompt or after a slow start
  task automatic send(input logic [2:0] e, input int gap);
    #(gap);
    port_o.evt = e;
    #24 port_o.link_clk = 1'b1;
    #24 port_o.link_clk = 1'b0;
    port_o.evt = ~e; // hold time over, code no longer valid
  endtask
endmodule

// >>> sim/tb_dpcs_top.sv
`timescale 1ns/100ps
// bench for the dual port control and status block
module tb_dpcs_top
  import dpcs_pkg::*;
;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0]  avs_address, temp_c, t;
  logic [31:0] avs_writedata, avs_readdata, lfsr;
  logic        unit_fault, noncat_fail, loss_imminent, overload;
  logic        input_present, input_ok, output_ok, enable_strap_n, snap;
  logic        main_out_on, input_lamp, output_lamp, module_present_out;
  logic [3:0]  bus_addr_low;
  logic        rs485_mode;
  logic [1:0]  addr_level_first, addr_level_second;
  dpcs_od_s    od_oe, od_o;
  dpcs_port_s  link [NPORT];
  logic [31:0] exp_q [$];
  int          fail_count, n_compared, n;

  dpcs_top #(.PG_HALF(20), .BLINK_HALF(8)) u_dpcs_top (
    .clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .port(link), .unit_fault(unit_fault),
    .noncat_fail(noncat_fail), .temp_c(temp_c),
    .loss_imminent(loss_imminent), .overload(overload),
    .input_present(input_present), .input_ok(input_ok),
    .output_ok(output_ok), .enable_strap_n(enable_strap_n),
    .rs485_mode(rs485_mode), .addr_level_first(addr_level_first),
    .addr_level_second(addr_level_second), .od_oe(od_oe), .od_o(od_o),
    .main_out_on(main_out_on), .bus_addr_low(bus_addr_low),
    .input_lamp(input_lamp), .output_lamp(output_lamp),
    .module_present_out(module_present_out)
  );
  dpcs_host u_host0 (.port_o(link[0]));
  dpcs_host u_host1 (.port_o(link[1]));

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
      check(32'h0, 32'h1);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // note {irq, attention} and have the monitor take a snapshot
  task automatic look(input logic [2:0] e);
    exp_q.push_back({29'h0, e});
    @(posedge clk);
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
  endtask

  // next random word
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  // one link frame, port one a little slower than port zero
  task automatic ev(input int p, input dpcs_evt_e e);
    if (p == 1)
      u_host1.send(e, 37);
    else
      u_host0.send(e, 0);
    repeat (5) @(posedge clk);
  endtask

  // cycles from one rise of a pin to the next
  task automatic measure(input bit sel, output int m);
    logic s, p;
    m = 0;
    p = sel ? input_lamp : od_oe.output_loss_warn;
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      s = sel ? input_lamp : od_oe.output_loss_warn;
      if (s && !p && m > 0)
        break;
      if (s && !p)
        m = 1;
      else if (m > 0)
        m++;
      p = s;
    end
  endtask

  // monitor: each result against the oldest note
  always @(posedge clk) begin
    if ((avs_read && !avs_waitrequest) || snap) begin
      if (exp_q.size() == 0)
        check(32'h0, 32'h1);
      else
        check(snap ? {29'h0, irq, od_oe.attention} : avs_readdata,
              exp_q.pop_front());
    end
  end

  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    finish_test;
  end

  // main sequence
  initial begin
    {avs_read, avs_write, unit_fault, noncat_fail, snap} = '0;
    {loss_imminent, overload, input_present, input_ok} = '0;
    {output_ok, enable_strap_n, reset} = 3'h7;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    temp_c = 8'h00;
    rs485_mode = 1'b0;
    addr_level_first = 2'b10;
    addr_level_second = 2'b01;
    lfsr = 32'd69659;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_CTRL, 32'h1);
    rd(OFS_BUS, 32'h001);
    rd(OFS_IMASK, 32'h0);
    rd(OFS_ADDR, 32'h9);
    rd(8'h18, 32'hdeadbeef);
    bus(1'b1, OFS_BUS, 32'hff);
    rd(OFS_BUS, 32'h001);
    check(32'(bus_addr_low), 32'h9);
    check(32'(module_present_out), 32'h0);
    $display("test reset done");
    ev(1, EV_CMD);
    look(3'b010);
    rd(OFS_BUS, 32'h0c1);
    bus(1'b1, OFS_IMASK, 32'h1);
    look(3'b110);
    rd(OFS_ISTAT, 32'h01);
    look(3'b010);
    ev(1, EV_CLEAR);
    rd(OFS_BUS, 32'h001);
    look(3'b000);
    bus(1'b1, OFS_IMASK, 32'h0);
    $display("test reject done");
    unit_fault <= 1'b1;
    settle;
    rd(OFS_BUS, 32'h001);
    look(3'b001);
    ev(1, EV_TAKEOVER);
    look(3'b011);
    rd(OFS_BUS, 32'h174);
    rd(OFS_UNIT, 32'h1);
    unit_fault <= 1'b0;
    settle;
    ev(1, EV_CLEAR);
    rd(OFS_BUS, 32'h114);
    look(3'b001);
    ev(0, EV_CLEAR);
    rd(OFS_BUS, 32'h110);
    look(3'b000);
    unit_fault <= 1'b1;
    settle;
    unit_fault <= 1'b0;
    settle;
    ev(0, EV_CLEAR);
    rd(OFS_UNIT, 32'h1);
    look(3'b010);
    ev(1, EV_CLEAR);
    rd(OFS_UNIT, 32'h0);
    look(3'b000);
    $display("test takeover done");
    ev(0, EV_CMD);
    rd(OFS_BUS, 32'h11c);
    look(3'b001);
    ev(1, EV_CLEAR);
    rd(OFS_BUS, 32'h11c);
    look(3'b001);
    ev(0, EV_CLEAR);
    rd(OFS_BUS, 32'h110);
    look(3'b000);
    ev(1, EV_BAD_CMD);
    rd(OFS_UNIT, 32'h00028000);
    look(3'b010);
    rd(OFS_BUS, 32'h110);
    ev(1, EV_CLEAR);
    rd(OFS_UNIT, 32'h0);
    noncat_fail <= 1'b1;
    settle;
    rd(OFS_UNIT, 32'h2);
    noncat_fail <= 1'b0;
    settle;
    ev(1, EV_CLEAR);
    look(3'b000);
    $display("test ownership done");
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      t = (i < 2) ? 8'(TEMP_SHDN_C - OTW_MARGIN_C - 1 + i) : lfsr[7:0];
      temp_c <= t;
      settle;
      check(32'(od_oe.overtemp_warn), 32'(t >= 8'(TEMP_SHDN_C - OTW_MARGIN_C)));
    end
    temp_c <= 8'h00;
    loss_imminent <= 1'b1;
    settle;
    check(32'(od_oe.output_loss_warn), 32'h1);
    loss_imminent <= 1'b0;
    overload <= 1'b1;
    measure(1'b0, n);
    check(32'(n), 32'd40);
    overload <= 1'b0;
    $display("test warnings done");
    enable_strap_n <= 1'b0;
    settle;
    check(32'(main_out_on), 32'h1);
    bus(1'b1, OFS_CTRL, 32'h0);
    settle;
    check(32'(main_out_on), 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1);
    enable_strap_n <= 1'b1;
    settle;
    check(32'(main_out_on), 32'h0);
    enable_strap_n <= 1'b0;
    rs485_mode <= 1'b1;
    input_ok <= 1'b1;
    settle;
    check(32'(main_out_on), 32'h0);
    check(32'(input_lamp), 32'h0);
    rs485_mode <= 1'b0;
    enable_strap_n <= 1'b1;
    settle;
    check(32'(input_lamp), 32'h1);
    input_ok <= 1'b0;
    input_present <= 1'b1;
    measure(1'b1, n);
    check(32'(n), 32'd16);
    $display("test pins done");
    settle;
    finish_test;
  end
endmodule
